// file: design/hs_pin_ctrl.sv
// Wake, reset, direct input, fault flag and sense select control
`timescale 1ns/1ps
// How it works
// [RULE1] SPI picks load current or temperature sense
// [RULE2] SPI can tri-state the sense output
// [RULE3] Any direct input wakes the device
// [RULE4] Direct input n drives output n
// [RULE5] External modulator clock comes on input zero
// [RULE6] Fault flag pulled low on any fault
// [RULE7] Fault detail only via serial output
// [RULE8] Wake pin high wakes the device
// [RULE9] Reset pin high also wakes
// [RULE10] Reset clears registers and enters sleep
// [RULE11] Reset rising edge starts the watchdog
// [RULE12] Host holds reset low ten microseconds
// [RULE13] Host serial clock at most eight megahertz
// [RULE14] Wake is OR of all sources
// [RULE15] Fail-safe: outputs follow direct inputs
// [RULE16] Pins pass two-stage synchroniser first
module hs_pin_ctrl
   import hs_pins_pkg::*;
#(
   parameter int unsigned WDOG_CYC = 32'd100000 // Watchdog period, cycles
)
(
   input  wire logic       clk_i,            // Core clock, 200 MHz
   input  wire logic       rst_i,            // Async reset, high
   input  wire logic [3:0] direct_input_i,   // Direct input pins
   input  wire logic       wake_i,           // Wake pin
   input  wire logic       reset_pin_i,      // Reset pin, low resets
   input  wire logic       fail_safe_i,      // Mode logic: fail-safe
   input  wire logic       pwm_en_i,         // Modulator drives outputs
   input  wire logic       pwm_ext_clk_i,    // Modulator uses pin clock
   input  wire logic [3:0] pwm_drive_i,      // Modulator output states
   input  wire logic [3:0] spi_on_i,         // Serial output on bits
   input  wire logic       fault_i,          // OR of detected faults
   input  wire logic       sense_temp_i,     // Sense shows temperature
   input  wire logic [1:0] sense_chan_i,     // Sense current channel
   input  wire logic       sense_off_i,      // Sense tri-state command
   input  wire logic       wdog_kick_i,      // Watchdog refresh
   output logic      [3:0] high_side_o,      // Output switch gates
   output logic            wake_o,           // Wake-up condition
   output logic            sleep_o,          // Low-current sleep
   output logic            regs_init_o,      // Clear config and faults
   output logic            wdog_run_o,       // Watchdog counting
   output logic            wdog_timeout_o,   // Watchdog expired
   output logic            pwm_clk_tick_o,   // Pin clock edge pulse
   output logic            fault_flag_o,     // Fault pin out level
   output logic            fault_flag_oe_o,  // Fault pin pull-down
   output logic      [4:0] sense_sel_o,      // One-hot sense source
   output logic            sense_oe_o        // Sense pin enable
);

   // ***************************************************
   // Pin synchronisation
   // ***************************************************
   pin_sync_if pins (); // Synchronised pin view for the core

   pin_sync u_sync (
      .clk_i          (clk_i),
      .rst_i          (rst_i),
      .direct_input_i (direct_input_i),
      .wake_i         (wake_i),
      .reset_pin_i    (reset_pin_i),
      .sync           (pins.prod)
   );

   // Saturating increment used by both counters
   function automatic logic [31:0] sat_inc(input logic [31:0] v,
                                           input logic [31:0] lim);
      sat_inc = (v >= lim) ? lim : v + 32'h1;
   endfunction : sat_inc

   // ***************************************************
   // Reset pin recognition
   // ***************************************************
   logic [RST_CNT_W-1:0] low_cnt;      // Cycles the pin has been low
   logic                 rst_held;     // Reset recognised and held
   logic [RST_CNT_W-1:0] next_low_cnt;
   logic                 next_rst_held;

   // Count low time; short glitches never reach the limit
   always_comb
   begin
      next_low_cnt  = low_cnt;
      next_rst_held = rst_held;
      if (pins.rst_level)
      begin
         next_low_cnt  = '0;
         next_rst_held = 1'b0;
      end
      else
      begin
         next_low_cnt = RST_CNT_W'(sat_inc(32'(low_cnt),
                                           32'(RST_LOW_CYC)));
         // [RULE12] ten microsecond low
         if (32'(next_low_cnt) >= RST_LOW_CYC)
            next_rst_held = 1'b1;
      end
   end

   // Register reset recognition
   always_ff @(posedge clk_i or posedge rst_i)
   begin
      if (rst_i)
      begin
         low_cnt  <= '0;
         rst_held <= 1'b1;
      end
      else
      begin
         low_cnt  <= next_low_cnt;
         rst_held <= next_rst_held;
      end
   end

   // ***************************************************
   // Watchdog
   // ***************************************************
   logic [31:0] wd_cnt;       // Cycles since start or refresh
   logic        wd_run;       // Counting
   logic [31:0] next_wd_cnt;
   logic        next_wd_run;

   // Start on reset release; a held reset stops it
   always_comb
   begin
      next_wd_cnt = wd_cnt;
      next_wd_run = wd_run;
      // [RULE11] start on rising edge
      // The rise lands while rst_held is still set, so it goes first
      if (pins.rst_rise)
      begin
         next_wd_run = 1'b1;
         next_wd_cnt = 32'h0;
      end
      else if (rst_held)
      begin
         next_wd_run = 1'b0;
         next_wd_cnt = 32'h0;
      end
      else if (wd_run)
         next_wd_cnt = wdog_kick_i ? 32'h0 : sat_inc(wd_cnt, WDOG_CYC);
   end

   // Register watchdog state
   always_ff @(posedge clk_i or posedge rst_i)
   begin
      if (rst_i)
      begin
         wd_cnt <= 32'h0;
         wd_run <= 1'b0;
      end
      else
      begin
         wd_cnt <= next_wd_cnt;
         wd_run <= next_wd_run;
      end
   end

   // ***************************************************
   // Pin-facing outputs
   // ***************************************************
   logic [3:0] next_high_side;
   logic       next_wake;
   logic       next_sleep;
   logic       next_tick;
   logic       next_flag_oe;
   logic [4:0] next_sense_sel;
   logic       next_sense_oe;

   // Decode outputs from pins and control settings
   always_comb
   begin
      // [RULE14] OR of wake sources
      // [RULE3] [RULE8] [RULE9] inputs, wake, reset
      next_wake = pins.rst_level | pins.wake_level | (|pins.in_level);
      // [RULE10] held reset forces sleep
      next_sleep = rst_held | ~next_wake;
      // [RULE15] fail-safe uses direct inputs
      if (fail_safe_i)
         next_high_side = pins.in_level;
      else if (pwm_en_i)
         next_high_side = pwm_drive_i;
      else
         // [RULE4] input n or SPI bit n
         next_high_side = pins.in_level | spi_on_i;
      if (rst_held)
         next_high_side = OUT_RST;
      // [RULE5] pin clock only in external mode
      next_tick = pwm_en_i & pwm_ext_clk_i & pins.in0_rise;
      // [RULE6] [RULE7] summary fault only
      next_flag_oe = fault_i & ~rst_held;
      // [RULE1] current channel or temperature
      next_sense_sel = SENSE_RST;
      if (sense_temp_i)
         next_sense_sel[SENSE_TEMP_BIT] = 1'b1;
      else
         next_sense_sel[sense_chan_i] = 1'b1;
      // [RULE2] tri-state on command
      next_sense_oe = ~sense_off_i & ~rst_held;
      if (!next_sense_oe)
         next_sense_sel = SENSE_RST;
   end

   // Register every top-level output except fault_flag_o
   always_ff @(posedge clk_i or posedge rst_i)
   begin
      if (rst_i)
      begin
         high_side_o     <= OUT_RST;
         wake_o          <= 1'b0;
         sleep_o         <= 1'b1;
         regs_init_o     <= 1'b1;
         wdog_run_o      <= 1'b0;
         wdog_timeout_o  <= 1'b0;
         pwm_clk_tick_o  <= 1'b0;
         fault_flag_oe_o <= 1'b0;
         sense_sel_o     <= SENSE_RST;
         sense_oe_o      <= 1'b0;
      end
      else
      begin
         high_side_o     <= next_high_side;
         wake_o          <= next_wake;
         sleep_o         <= next_sleep;
         // [RULE10] init while reset held
         regs_init_o     <= next_rst_held;
         wdog_run_o      <= next_wd_run;
         wdog_timeout_o  <= next_wd_run & (next_wd_cnt >= WDOG_CYC);
         pwm_clk_tick_o  <= next_tick;
         fault_flag_oe_o <= next_flag_oe;
         sense_sel_o     <= next_sense_sel;
         sense_oe_o      <= next_sense_oe;
      end
   end

   // Open drain: only ever drives low
   always_ff @(posedge clk_i or posedge rst_i)
   begin
      if (rst_i)
         fault_flag_o <= 1'b0;
      else
         fault_flag_o <= 1'b0;
   end

endmodule : hs_pin_ctrl

// file: design/hs_pins_pkg.sv
// Constants shared by the pin-level wake, reset and input control logic
package hs_pins_pkg;

   // ***************************************************
   // Clock and timing
   // ***************************************************
   localparam int unsigned CLK_MHZ         = 200;  // Core clock rate
   localparam int unsigned RST_LOW_MIN_US  = 10;   // Least reset low time
   // Least time rounds up; whole microseconds times MHz is exact
   localparam int unsigned RST_LOW_CYC     = RST_LOW_MIN_US * CLK_MHZ;
   localparam int unsigned RST_CNT_W       = $clog2(RST_LOW_CYC + 1);
   localparam int unsigned SPI_MAX_KHZ     = 8000; // Host side limit only

   // ***************************************************
   // Widths and reset values
   // ***************************************************
   localparam int unsigned NUM_OUT         = 4;    // Number of channels
   localparam int unsigned SYNC_STAGES     = 2;    // Synchroniser depth
   localparam logic [3:0]  OUT_RST         = 4'h0; // Outputs off
   localparam logic [4:0]  SENSE_RST       = 5'h00;// No sense source
   localparam int unsigned SENSE_TEMP_BIT  = 4;    // Temperature select bit

endpackage : hs_pins_pkg

// file: design/pin_sync_if.sv
// Carrier of synchronised pin levels and the reset pin and input zero rising edges
`timescale 1ns/1ps
interface pin_sync_if;
   logic [3:0] in_level;   // Direct inputs, clock domain
   logic       wake_level; // Wake pin, clock domain
   logic       rst_level;  // Reset pin, clock domain
   logic       rst_rise;   // Reset pin went low to high
   logic       in0_rise;   // Direct input zero rising edge

   modport prod (output in_level, wake_level, rst_level, rst_rise,
                 in0_rise);
   modport cons (input  in_level, wake_level, rst_level, rst_rise,
                 in0_rise);
endinterface : pin_sync_if

// file: design/pin_sync.sv
// Two-stage synchroniser for the asynchronous pins, rising edge finder for the reset pin and input zero
`timescale 1ns/1ps
module pin_sync
   import hs_pins_pkg::*;
(
   input  wire logic       clk_i,           // Core clock
   input  wire logic       rst_i,           // Async reset, high
   input  wire logic [3:0] direct_input_i,  // Raw direct inputs
   input  wire logic       wake_i,          // Raw wake pin
   input  wire logic       reset_pin_i,     // Raw reset pin
   pin_sync_if.prod        sync             // Synchronised view
);

   // ***************************************************
   // Synchroniser stages
   // ***************************************************
   logic [5:0] meta;       // First stage, read only by stage two
   logic [5:0] stable;     // Second stage, safe to use
   logic [5:0] last;       // Previous stable value, for edges
   logic [5:0] next_meta;
   logic [5:0] next_stable;
   logic [5:0] next_last;

   // Next values: shift raw pins through the stages
   always_comb
   begin
      next_meta   = {reset_pin_i, wake_i, direct_input_i};
      next_stable = meta;
      next_last   = stable;
   end

   // [RULE16] two flops per pin
   always_ff @(posedge clk_i or posedge rst_i)
   begin
      if (rst_i)
      begin
         meta   <= 6'h00;
         stable <= 6'h00;
         last   <= 6'h00;
      end
      else
      begin
         meta   <= next_meta;
         stable <= next_stable;
         last   <= next_last;
      end
   end

   // ***************************************************
   // Outputs to the core
   // ***************************************************
   // Edges compare stage two with its delayed copy, never stage one
   assign sync.in_level   = stable[3:0];
   assign sync.wake_level = stable[4];
   assign sync.rst_level  = stable[5];
   assign sync.rst_rise   = stable[5] & ~last[5];
   // [RULE5] external clock edges
   assign sync.in0_rise   = stable[0] & ~last[0];

endmodule : pin_sync

// file: bench/hs_pin_ctrl_sva.sv
// Checker for the pin control block
`timescale 1ns/1ps
module hs_pin_ctrl_sva (
   input wire logic       clk_i,
   input wire logic       rst_i,
   input wire logic [3:0] direct_input_i,
   input wire logic       wake_i,
   input wire logic       reset_pin_i,
   input wire logic       fail_safe_i,
   input wire logic       pwm_en_i,
   input wire logic       pwm_ext_clk_i,
   input wire logic       fault_i,
   input wire logic       sense_temp_i,
   input wire logic [1:0] sense_chan_i,
   input wire logic       sense_off_i,
   input wire logic [3:0] high_side_o,
   input wire logic       wake_o,
   input wire logic       sleep_o,
   input wire logic       regs_init_o,
   input wire logic       wdog_run_o,
   input wire logic       pwm_clk_tick_o,
   input wire logic       fault_flag_o,
   input wire logic       fault_flag_oe_o,
   input wire logic [4:0] sense_sel_o,
   input wire logic       sense_oe_o
);
   // ****
   // Properties, pins need three cycles
   // ****
   default clocking cb @(posedge clk_i); endclocking
   default disable iff (rst_i);
   // Pin rises while registers held
   sequence rst_release;
      regs_init_o ##1 $rose(reset_pin_i);
   endsequence
   sequence wdog_up;
      wdog_run_o && !regs_init_o;
   endsequence
   AST_WDOG_START: assert property (rst_release |-> ##[1:5] wdog_up)
      else $error("watchdog not started by reset pin");
   AST_RESET_OFF: assert property (regs_init_o [*2] |-> sleep_o &&
      high_side_o == 4'h0 && !wdog_run_o && !sense_oe_o)
      else $error("outputs live while reset held");
   AST_WAKE_PIN: assert property (wake_i [*4] |-> wake_o)
      else $error("wake pin ignored");
   AST_WAKE_IN: assert property ((|direct_input_i) [*4] |-> wake_o)
      else $error("direct input did not wake");
   AST_WAKE_RST: assert property (reset_pin_i [*4] |-> wake_o)
      else $error("reset pin did not wake");
   AST_FS_DRIVE: assert property ((fail_safe_i && !regs_init_o &&
      $stable(direct_input_i)) [*4] |-> high_side_o == direct_input_i)
      else $error("outputs not following inputs");
   AST_SENSE_OFF: assert property (sense_off_i |=> !sense_oe_o)
      else $error("sense driven while off");
   AST_SENSE_SEL: assert property (sense_oe_o |-> sense_sel_o ==
      ($past(sense_temp_i) ? 5'h10 : 5'h01 << $past(sense_chan_i)))
      else $error("sense source wrong");
   AST_FLAG_LOW: assert property ((fault_i && !regs_init_o) [*2]
      |-> fault_flag_oe_o && !fault_flag_o)
      else $error("fault flag not pulled low");
   AST_FLAG_REL: assert property (!fault_i |=> !fault_flag_oe_o)
      else $error("fault flag not released");
   AST_TICK_GATE: assert property (pwm_clk_tick_o |->
      $past(pwm_en_i) && $past(pwm_ext_clk_i))
      else $error("tick without pin clock mode");
   AST_TICK: assert property ($rose(direct_input_i[0]) && pwm_en_i &&
      pwm_ext_clk_i |-> ##[1:5] pwm_clk_tick_o)
      else $error("pin clock edge lost");
endmodule : hs_pin_ctrl_sva

bind hs_pin_ctrl hs_pin_ctrl_sva u_sva (.clk_i(clk_i), .rst_i(rst_i),
   .direct_input_i(direct_input_i), .wake_i(wake_i),
   .reset_pin_i(reset_pin_i), .fail_safe_i(fail_safe_i),
   .pwm_en_i(pwm_en_i), .pwm_ext_clk_i(pwm_ext_clk_i), .fault_i(fault_i),
   .sense_temp_i(sense_temp_i), .sense_chan_i(sense_chan_i),
   .sense_off_i(sense_off_i), .high_side_o(high_side_o), .wake_o(wake_o),
   .sleep_o(sleep_o), .regs_init_o(regs_init_o), .wdog_run_o(wdog_run_o),
   .pwm_clk_tick_o(pwm_clk_tick_o), .fault_flag_o(fault_flag_o),
   .fault_flag_oe_o(fault_flag_oe_o), .sense_sel_o(sense_sel_o),
   .sense_oe_o(sense_oe_o));

// file: bench/host_model.sv
// Host model driving the parallel pins
`timescale 1ns/1ps
module host_model import hs_pins_pkg::*; (
   output logic [3:0] direct_input_o,
   output logic       wake_o,
   output logic       reset_pin_o
);
   logic [3:0] level;    // Static input levels
   logic       link_on;  // Pin clock running
   logic       link_clk; // Pin clock, 160 ns
   initial
   begin
      level = 4'h0;
      link_on = 1'b0;
      link_clk = 1'b0;
      wake_o = 1'b0;
      reset_pin_o = 1'b0;
   end
   // clock on input zero, still outside frames
   always #80 link_clk = link_on ? ~link_clk : 1'b0;
   assign direct_input_o = {level[3:1], link_on ? link_clk : level[0]};
   // no serial clock made here, so never over limit
   task automatic set_pins(input logic [3:0] v, input logic w);
      level = v;
      wake_o = w;
   endtask : set_pins
   task automatic reset_low;
      reset_pin_o = 1'b0;
      #(RST_LOW_MIN_US * 1000 + 100);
   endtask : reset_low
endmodule : host_model

// file: bench/tb.sv
// Self-checking bench for the pin control block
`timescale 1ns/1ps
module tb import hs_pins_pkg::*;;
   logic clk_i, rst_i, wake, rpin, fs, pen, pext, flt, stemp, soff, kick;
   logic [3:0] din, pdrv, spi, hs;
   logic [1:0] chan;
   logic [4:0] ssel;
   logic wk, slp, init, wrun, wto, tick, fo, foe, soe, in0_prev;
   int fails, checks_done, cyc, n, r;
   host_model u_host (.direct_input_o(din), .wake_o(wake),
      .reset_pin_o(rpin));
   hs_pin_ctrl #(.WDOG_CYC(50)) u_dut (.clk_i(clk_i), .rst_i(rst_i),
      .direct_input_i(din), .wake_i(wake), .reset_pin_i(rpin),
      .fail_safe_i(fs), .pwm_en_i(pen), .pwm_ext_clk_i(pext),
      .pwm_drive_i(pdrv), .spi_on_i(spi), .fault_i(flt),
      .sense_temp_i(stemp), .sense_chan_i(chan), .sense_off_i(soff),
      .wdog_kick_i(kick), .high_side_o(hs), .wake_o(wk), .sleep_o(slp),
      .regs_init_o(init), .wdog_run_o(wrun), .wdog_timeout_o(wto),
      .pwm_clk_tick_o(tick), .fault_flag_o(fo), .fault_flag_oe_o(foe),
      .sense_sel_o(ssel), .sense_oe_o(soe));
   initial
   begin
      clk_i = 1'b0;
      forever #2.5 clk_i = ~clk_i;
   end
   // Hang guard, run needs about 3000 cycles
   always @(posedge clk_i)
   begin
      cyc++;
      if (cyc == 20000)
      begin
         fails++;
         print_verdict();
      end
   end
   task automatic chk(input string nm, input logic [4:0] seen, exp);
      checks_done++;
      if (seen !== exp)
      begin
         fails++;
         $display("mismatch %s exp %h seen %h", nm, exp, seen);
      end
   endtask : chk
   task automatic step(input int k);
      repeat (k) @(posedge clk_i);
      #1;
   endtask : step
   task automatic print_verdict;
      $display("checks %0d fails %0d", checks_done, fails);
      if (fails == 0 && checks_done > 0)
         $display("SIMULATION PASSED");
      else
         $display("SIMULATION FAILED");
      $finish;
   endtask : print_verdict
   // Leave held reset, then a full recognised reset
   task automatic t_reset;
      chk("init", 5'(init), 5'h1);
      rpin_set(1'b1);
      step(6);
      chk("wrun", 5'(wrun), 5'h1);
      chk("init", 5'(init), 5'h0);
      chk("wake", 5'(wk), 5'h1);
      spi = 4'hf;
      u_host.reset_low();
      chk("init", 5'(init), 5'h1);
      chk("hs", 5'(hs), 5'h0);
      chk("sleep", 5'(slp), 5'h1);
      rpin_set(1'b1);
      step(60);
      chk("wto", 5'(wto), 5'h1);
      kick = 1'b1;
      step(1);
      kick = 1'b0;
      step(2);
      chk("wto", 5'(wto), 5'h0);
      spi = 4'h0;
   endtask : t_reset
   task automatic rpin_set(input logic v);
      u_host.reset_pin_o = v;
   endtask : rpin_set
   // Short reset low: wake pin alone, then direct input alone
   task automatic t_wake;
      rpin_set(1'b0);
      step(5);
      chk("wake", 5'(wk), 5'h0);
      u_host.set_pins(4'h0, 1'b1);
      step(4);
      chk("wake", 5'(wk), 5'h1);
      u_host.set_pins(4'h8, 1'b0);
      step(4);
      chk("wake", 5'(wk), 5'h1);
      u_host.set_pins(4'h0, 1'b0);
      rpin_set(1'b1);
      step(4);
   endtask : t_wake
   // Normal, fail-safe and modulator drive
   task automatic t_drive;
      u_host.set_pins(4'ha, 1'b0);
      step(4);
      chk("hs", 5'(hs), 5'ha);
      spi = 4'h5;
      fs = 1'b1;
      u_host.set_pins(4'h3, 1'b0);
      step(4);
      chk("hs", 5'(hs), 5'h3);
      fs = 1'b0;
      u_host.set_pins(4'h0, 1'b0);
      spi = 4'h0;
      pen = 1'b1;
      pext = 1'b1;
      pdrv = 4'h6;
      step(2);
      chk("hs", 5'(hs), 5'h6);
      for (int m = 0; m < 2; m++)
      begin
         pext = (m == 0);
         n = 0;
         r = 0;
         in0_prev = 1'b0;
         u_host.link_on = 1'b1;
         // Stop the pin clock early so the last tick still lands
         for (int i = 0; i < 404; i++)
         begin
            if (i == 400)
               u_host.link_on = 1'b0;
            step(1);
            r += (din[0] && !in0_prev) ? 1 : 0;
            in0_prev = din[0];
            n += tick;
         end
         chk("rises", 5'(r != 0), 5'h1);
         chk("ticks", 5'(n), m == 0 ? 5'(r) : 5'h0);
      end
      pen = 1'b0;
      pext = 1'b0;
   endtask : t_drive
   // Sense select, tri-state and fault flag
   task automatic t_sense;
      for (int c = 0; c < 5; c++)
      begin
         chan = 2'(c);
         stemp = (c == 4);
         step(2);
         chk("ssel", ssel, c == 4 ? 5'h10 : 5'h01 << c);
      end
      soff = 1'b1;
      flt = 1'b1;
      step(2);
      chk("soe", 5'(soe), 5'h0);
      chk("ssel", ssel, 5'h00);
      chk("flag", {3'h0, foe, fo}, 5'h2);
      flt = 1'b0;
      step(2);
      chk("flag", 5'(foe), 5'h0);
   endtask : t_sense
   initial
   begin
      {rst_i, fs, pen, pext, flt, stemp, soff, kick} = 8'h80;
      {pdrv, spi, chan} = 10'h000;
      step(6);
      rst_i = 1'b0;
      step(3);
      t_reset();
      t_wake();
      t_drive();
      t_sense();
      print_verdict();
   end
endmodule : tb
